// ### rtl/spe_pkg.sv
// shared constants, modes and carrier types of the serial port unit
package spe_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int unsigned REF_CLK_HZ = 20000000;
  localparam int unsigned I2C_STD_BPS = 100000;
  localparam int unsigned SCL_HALF_CYCLES = REF_CLK_HZ / (2 * I2C_STD_BPS);
  localparam int TIMER_W = 16;
  localparam logic [TIMER_W-1:0] SCL_HALF_T = TIMER_W'(SCL_HALF_CYCLES);
  localparam logic [TIMER_W-1:0] TIMER_ZERO = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // framing
  localparam int BYTE_W = 8;
  localparam int ADDR_W = 7;
  localparam int TX_FIFO_DEPTH = 16;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [3:0] ACK_SLOT = 4'h8;
  localparam logic [2:0] SPI_BIT_FIRST = 3'h0;
  localparam logic [2:0] SPI_BIT_LAST = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [2:0] {
    M_IDLE,
    M_WAIT,
    M_START,
    M_BIT,
    M_HOLD,
    M_STOP
  } spe_mstate_t;

  typedef struct packed {
    logic multi_master_select;
    logic transmitter_select;
    logic [ADDR_W-1:0] slave_addr;
  } spe_ctrl_t;

  typedef struct packed {
    logic not_ack;
    logic stop_detected;
    logic start_detected;
  } spe_flags_t;

endpackage

// ### rtl/spe_fifo.sv
// synchronous fifo of flip-flops with valid/ready on both sides
`timescale 1ns/1ps
module spe_fifo
  import spe_pkg::*;
#(
  parameter int WIDTH = BYTE_W,
  parameter int DEPTH = TX_FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  // filling side
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  // draining side
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_idx;
    logic [AW-1:0] rd_idx;
    logic [CW-1:0] count;
    logic ready;
  } spe_fifo_st_t;

  spe_fifo_st_t st_q;
  spe_fifo_st_t st_d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] next_idx(input logic [AW-1:0] i);
    next_idx = (i == LAST_IDX) ? '0 : AW'(i + 1'b1);
  endfunction

  assign in_ready = st_q.ready;
  assign out_valid = (st_q.count != '0);
  assign out_data = st_q.mem[st_q.rd_idx];
  assign push = in_valid && st_q.ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    st_d = st_q;
    if (push) begin
      st_d.mem[st_q.wr_idx] = in_data;
      st_d.wr_idx = next_idx(st_q.wr_idx);
    end
    if (pop) begin
      st_d.rd_idx = next_idx(st_q.rd_idx);
    end
    if (push && !pop) begin
      st_d.count = CW'(st_q.count + 1'b1);
    end else if (pop && !push) begin
      st_d.count = CW'(st_q.count - 1'b1);
    end
    // flush drops whatever is held, including a word pushed this cycle
    if (flush) begin
      st_d.rd_idx = st_d.wr_idx;
      st_d.count = '0;
    end
    st_d.ready = (st_d.count != FULL_CNT);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ### rtl/spe_serial_port.sv
// serial port unit: multi-master i2c transmitter and spi slave
`timescale 1ns/1ps

module spe_serial_port
  import spe_pkg::*;
(
  // clocks and reset
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic spi_sclk,
  // i2c master control
  input wire spe_ctrl_t ctrl,
  input wire logic start_request,
  input wire logic stop_request,
  output logic start_request_flag,
  output logic bus_busy_indicator,
  // i2c transmit stream
  input wire logic [BYTE_W-1:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic transmit_interrupt_flag,
  input wire logic tx_flag_clear,
  // bus event flags
  output spe_flags_t event_flags,
  input wire spe_flags_t flag_clear,
  input wire spe_flags_t irq_enable,
  input wire logic global_irq_enable,
  output logic irq_request,
  output logic irq_hazard,
  // i2c pins
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // spi slave pins
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  // spi slave control and data
  input wire logic clock_phase_select,
  input wire logic bit_order_select,
  input wire logic [BYTE_W-1:0] spi_tx_data,
  input wire logic spi_tx_write,
  output logic [BYTE_W-1:0] spi_rx_data,
  output logic spi_rx_valid
);

  ////////////////////////////////////////////////////////////////////////////
  // state of the reference clock domain
  typedef struct packed {
    spe_mstate_t state;
    logic [TIMER_W-1:0] timer;
    logic high_half;
    logic [3:0] bitn;
    logic [BYTE_W:0] sh;
    logic addr_phase;
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic busy;
    logic start_flag;
    logic stop_pend;
    logic txif;
    spe_flags_t flags;
    logic gie_p;
    logic gie_rose;
    logic hazard;
    logic irq;
    logic scl_oe;
    logic sda_oe;
    logic pin_low;
    logic [BYTE_W-1:0] spi_tx;
    logic spi_tx_tgl;
    logic rxt_m;
    logic rxt_s;
    logic rxt_p;
    logic [BYTE_W-1:0] spi_rx;
    logic spi_rx_vld;
  } spe_ref_st_t;

  // state of the spi link clock domain
  typedef struct packed {
    logic cph_m;
    logic cph_s;
    logic msb_m;
    logic msb_s;
    logic txt_m;
    logic txt_s;
    logic txt_seen;
    logic [BYTE_W-1:0] sh;
    logic [BYTE_W-1:0] last;
    logic [BYTE_W-1:0] rsh;
    logic [2:0] cnt;
    logic miso;
    logic [BYTE_W-1:0] rx_data;
    logic rx_tgl;
  } spe_lnk_st_t;

  spe_ref_st_t r_q;
  spe_ref_st_t r_d;
  spe_lnk_st_t l_q;
  spe_lnk_st_t l_d;

  logic [BYTE_W-1:0] fifo_data;
  logic fifo_valid;
  logic fifo_pop;
  logic fifo_flush;
  logic start_ev;
  logic stop_ev;
  logic scl_fall;
  logic [2:0] hw_set;
  logic [2:0] hw_clr;
  logic [2:0] flags_nx;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [BYTE_W-1:0] spi_shift(input logic [BYTE_W-1:0] d,
                                                  input logic msb);
    spi_shift = msb ? {d[BYTE_W-2:0], 1'b0} : {1'b0, d[BYTE_W-1:1]};
  endfunction

  function automatic logic spi_out_bit(input logic [BYTE_W-1:0] d, input logic msb);
    spi_out_bit = msb ? d[BYTE_W-1] : d[0];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // transmit fifo; flushed while the start waits for the bus

  assign fifo_flush = (r_q.state == M_WAIT);
  assign fifo_pop = (r_q.state == M_HOLD) && fifo_valid;

  spe_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(TX_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk(ref_clk),
    .rstn(rstn),
    .flush(fifo_flush),
    .in_data(tx_data),
    .in_valid(tx_valid),
    .in_ready(tx_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop)
  );

  ////////////////////////////////////////////////////////////////////////////
  // bus condition decode on synchronised pins

  assign start_ev = r_q.scl_s && r_q.scl_p && r_q.sda_p && !r_q.sda_s;
  assign stop_ev = r_q.scl_s && r_q.scl_p && !r_q.sda_p && r_q.sda_s;
  assign scl_fall = r_q.scl_p && !r_q.scl_s;

  ////////////////////////////////////////////////////////////////////////////
  // reference domain next state

  always_comb begin
    r_d = r_q;
    hw_set = '0;
    hw_clr = '0;
    flags_nx = '0;
    r_d.scl_m = scl_i;
    r_d.scl_s = r_q.scl_m;
    r_d.scl_p = r_q.scl_s;
    r_d.sda_m = sda_i;
    r_d.sda_s = r_q.sda_m;
    r_d.sda_p = r_q.sda_s;
    r_d.pin_low = 1'b0;
    r_d.hazard = 1'b0;
    r_d.spi_rx_vld = 1'b0;
    if (r_q.timer != TIMER_ZERO) begin
      r_d.timer = TIMER_W'(r_q.timer - 1'b1);
    end
    if (start_ev) begin
      r_d.busy = 1'b1;
    end else if (stop_ev) begin
      r_d.busy = 1'b0;
    end
    if (stop_request) begin
      r_d.stop_pend = 1'b1;
    end
    if (tx_flag_clear) begin
      r_d.txif = 1'b0;
    end
    if (start_request) begin
      r_d.start_flag = 1'b1;
    end

    case (r_q.state)
      M_IDLE: begin
        r_d.scl_oe = 1'b0;
        r_d.sda_oe = 1'b0;
        if (r_q.start_flag) begin
          if (ctrl.multi_master_select && ctrl.transmitter_select && r_q.busy) begin
            r_d.state = M_WAIT;
          end else begin
            r_d.state = M_START;
            r_d.sda_oe = 1'b1;
            r_d.timer = SCL_HALF_T;
          end
        end
      end
      M_WAIT: begin
        // foreign clocking still reaches the flag here, as the silicon does
        if (scl_fall) begin
          r_d.txif = 1'b1;
        end
        if (!r_q.busy) begin
          r_d.state = M_START;
          r_d.sda_oe = 1'b1;
          r_d.timer = SCL_HALF_T;
        end
      end
      M_START: begin
        if (r_q.timer == TIMER_ZERO) begin
          r_d.state = M_BIT;
          r_d.scl_oe = 1'b1;
          r_d.sh = {ctrl.slave_addr, !ctrl.transmitter_select, 1'b1};
          r_d.sda_oe = !ctrl.slave_addr[ADDR_W-1];
          r_d.bitn = BIT_FIRST;
          r_d.high_half = 1'b0;
          r_d.addr_phase = 1'b1;
          r_d.timer = SCL_HALF_T;
        end
      end
      M_BIT: begin
        if (!r_q.high_half) begin
          if (r_q.timer == TIMER_ZERO) begin
            r_d.scl_oe = 1'b0;
            r_d.high_half = 1'b1;
            r_d.timer = SCL_HALF_T;
          end
        end else if (!r_q.scl_s) begin
          // a slave stretching the clock holds the high half open
          r_d.timer = SCL_HALF_T;
        end else if (r_q.timer == TIMER_ZERO) begin
          r_d.scl_oe = 1'b1;
          r_d.high_half = 1'b0;
          r_d.timer = SCL_HALF_T;
          if (r_q.bitn == ACK_SLOT) begin
            if (r_q.addr_phase) begin
              // a request landing in this very cycle keeps the flag up
              r_d.start_flag = start_request;
              r_d.addr_phase = 1'b0;
            end
            if (r_q.sda_s) begin
              hw_set[2] = 1'b1;
              r_d.state = M_STOP;
              r_d.sda_oe = 1'b1;
            end else begin
              r_d.state = M_HOLD;
              r_d.sda_oe = 1'b0;
            end
          end else begin
            r_d.bitn = 4'(r_q.bitn + 1'b1);
            r_d.sh = {r_q.sh[BYTE_W-1:0], 1'b1};
            r_d.sda_oe = !r_q.sh[BYTE_W-1];
          end
        end
      end
      M_HOLD: begin
        // master holds scl low until data or a stop is asked for
        r_d.scl_oe = 1'b1;
        r_d.high_half = 1'b0;
        if (fifo_valid) begin
          r_d.state = M_BIT;
          r_d.sh = {fifo_data, 1'b1};
          r_d.sda_oe = !fifo_data[BYTE_W-1];
          r_d.bitn = BIT_FIRST;
          r_d.timer = SCL_HALF_T;
          r_d.txif = 1'b1;
        end else if (r_q.stop_pend) begin
          r_d.state = M_STOP;
          r_d.sda_oe = 1'b1;
          r_d.timer = SCL_HALF_T;
        end
      end
      M_STOP: begin
        if (r_q.scl_oe) begin
          if (r_q.timer == TIMER_ZERO) begin
            r_d.scl_oe = 1'b0;
            r_d.timer = SCL_HALF_T;
          end
        end else if (r_q.scl_s && r_q.timer == TIMER_ZERO) begin
          r_d.sda_oe = 1'b0;
          r_d.stop_pend = 1'b0;
          r_d.state = M_IDLE;
        end
      end
      default: begin
        r_d.state = M_IDLE;
        r_d.scl_oe = 1'b0;
        r_d.sda_oe = 1'b0;
      end
    endcase

    // event flags: bus events set, opposite bus events clear; a set wins
    hw_set[0] = start_ev;
    hw_set[1] = stop_ev;
    hw_clr[0] = stop_ev;
    hw_clr[1] = start_ev;
    hw_clr[2] = start_ev;
    flags_nx = (r_q.flags & ~flag_clear & ~hw_clr) | hw_set;
    r_d.flags = flags_nx;

    // enabled flag dropped by the bus in the cycle of, or the cycle after, the rise of global enable
    r_d.gie_p = global_irq_enable;
    r_d.gie_rose = global_irq_enable && !r_q.gie_p;
    if (global_irq_enable && (!r_q.gie_p || r_q.gie_rose)) begin
      r_d.hazard = |(r_q.flags & irq_enable & hw_clr & ~hw_set);
    end
    r_d.irq = global_irq_enable && |(flags_nx & irq_enable);

    // spi transmit buffer write, handed over by toggle
    if (spi_tx_write) begin
      r_d.spi_tx = spi_tx_data;
      r_d.spi_tx_tgl = !r_q.spi_tx_tgl;
    end

    // spi received byte, announced by toggle from the link domain
    r_d.rxt_m = l_q.rx_tgl;
    r_d.rxt_s = r_q.rxt_m;
    r_d.rxt_p = r_q.rxt_s;
    if (r_q.rxt_s != r_q.rxt_p) begin
      r_d.spi_rx = l_q.rx_data;
      r_d.spi_rx_vld = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // spi link domain next state
  // limitation: a buffer write must not land while its toggle is in flight

  always_comb begin
    l_d = l_q;
    l_d.cph_m = clock_phase_select;
    l_d.cph_s = l_q.cph_m;
    l_d.msb_m = bit_order_select;
    l_d.msb_s = l_q.msb_m;
    l_d.txt_m = r_q.spi_tx_tgl;
    l_d.txt_s = l_q.txt_m;
    if (spi_cs_n) begin
      l_d.cnt = SPI_BIT_FIRST;
      if (l_q.txt_s != l_q.txt_seen) begin
        l_d.sh = r_q.spi_tx;
        l_d.last = r_q.spi_tx;
        l_d.txt_seen = l_q.txt_s;
      end
      l_d.miso = spi_out_bit(l_d.sh, l_q.msb_s);
    end else begin
      l_d.rsh = l_q.msb_s ? {l_q.rsh[BYTE_W-2:0], spi_mosi}
                          : {spi_mosi, l_q.rsh[BYTE_W-1:1]};
      l_d.sh = spi_shift(l_q.sh, l_q.msb_s);
      l_d.cnt = 3'(l_q.cnt + 1'b1);
      if (l_q.cnt == SPI_BIT_LAST) begin
        l_d.rx_data = l_d.rsh;
        l_d.rx_tgl = !l_q.rx_tgl;
        if (l_q.txt_s != l_q.txt_seen) begin
          l_d.sh = r_q.spi_tx;
          l_d.last = r_q.spi_tx;
          l_d.txt_seen = l_q.txt_s;
        end else if (l_q.cph_s) begin
          // stale preload moved on by the capture of the received byte
          l_d.sh = spi_shift(l_q.last, l_q.msb_s);
          l_d.last = l_d.sh;
        end else begin
          l_d.sh = l_q.last;
        end
      end
      l_d.miso = spi_out_bit(l_d.sh, l_q.msb_s);
    end
  end

  always_ff @(posedge spi_sclk or negedge rstn) begin
    if (!rstn) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign start_request_flag = r_q.start_flag;
  assign bus_busy_indicator = r_q.busy;
  assign transmit_interrupt_flag = r_q.txif;
  assign event_flags = r_q.flags;
  assign irq_request = r_q.irq;
  assign irq_hazard = r_q.hazard;
  assign scl_o = r_q.pin_low;
  assign scl_oe = r_q.scl_oe;
  assign sda_o = r_q.pin_low;
  assign sda_oe = r_q.sda_oe;
  assign spi_miso = l_q.miso;
  assign spi_rx_data = r_q.spi_rx;
  assign spi_rx_valid = r_q.spi_rx_vld;

endmodule

// ### bench/spe_serial_port_chk.sv
// assertion checker on the ports of the serial port unit
`timescale 1ns/1ps
module spe_serial_port_chk
  import spe_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // i2c master
  input wire spe_ctrl_t ctrl,
  input wire logic start_request,
  input wire logic start_request_flag,
  input wire logic bus_busy_indicator,
  input wire logic scl_oe,
  input wire logic sda_oe,
  // flags, interrupt and spi
  input wire spe_flags_t event_flags,
  input wire spe_flags_t flag_clear,
  input wire spe_flags_t irq_enable,
  input wire logic global_irq_enable,
  input wire logic irq_request,
  input wire logic irq_hazard,
  input wire logic spi_rx_valid
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  // a start requested onto a bus that stays busy for a while
  sequence s_wait_entry;
    $rose(start_request_flag) && ctrl.multi_master_select && ctrl.transmitter_select;
  endsequence
  sequence s_busy_run;
    bus_busy_indicator [*5];
  endsequence
  AST_START_TAKEN: assert property (start_request |=> start_request_flag)
    else $error("start request not taken");
  AST_WAIT_IDLE: assert property (s_wait_entry ##0 s_busy_run |=> !sda_oe && !scl_oe)
    else $error("bus driven while busy");
  AST_BUSY_ON_START: assert property (
    $rose(bus_busy_indicator) |-> event_flags.start_detected)
    else $error("busy without start flag");
  AST_START_CLEAR: assert property ($fell(event_flags.start_detected) |->
    $past(flag_clear.start_detected) || event_flags.stop_detected)
    else $error("start flag lost");
  AST_NACK_CLEAR: assert property ($fell(event_flags.not_ack) |->
    $past(flag_clear.not_ack) || event_flags.start_detected)
    else $error("nack flag lost");
  AST_IRQ_LEVEL: assert property (irq_request == ($past(global_irq_enable) &&
    (event_flags & $past(irq_enable)) != 3'h0))
    else $error("irq request mismatch");
  AST_HAZARD_PULSE: assert property (
    irq_hazard |-> $past(global_irq_enable) ##1 !irq_hazard)
    else $error("hazard pulse misplaced");
  AST_RX_PULSE: assert property (spi_rx_valid |=> !spi_rx_valid)
    else $error("rx valid longer than one cycle");
endmodule
bind spe_serial_port spe_serial_port_chk i_chk (.ref_clk(ref_clk), .rstn(rstn), .ctrl(ctrl),
  .start_request(start_request), .start_request_flag(start_request_flag),
  .bus_busy_indicator(bus_busy_indicator), .scl_oe(scl_oe), .sda_oe(sda_oe),
  .event_flags(event_flags), .flag_clear(flag_clear), .irq_enable(irq_enable),
  .global_irq_enable(global_irq_enable), .irq_request(irq_request),
  .irq_hazard(irq_hazard), .spi_rx_valid(spi_rx_valid));

// ### bench/spe_i2c_partner.sv
// i2c far side: an acknowledging slave that records bytes, and a foreign master
`timescale 1ns/1ps
module spe_i2c_partner #(
  parameter int HALF_NS = 4000
) (
  // wire levels
  input wire logic scl,
  input wire logic sda,
  // pull-downs, high while pulling low
  output logic scl_pd,
  output logic sda_pd
);
  logic [7:0] got_q[$];
  logic [7:0] sh;
  logic nack_mode, m_scl, m_sda, s_sda;
  int bits;
  initial {nack_mode, m_scl, m_sda, s_sda, bits} = '0;
  assign scl_pd = m_scl;
  assign sda_pd = m_sda | s_sda;
  ////////////////////////////////////////////////////////////
  // a start condition restarts byte framing
  always @(negedge sda) if (scl === 1'b1) bits = 0;
  always @(posedge scl) begin
    sh = {sh[6:0], sda};
    bits = bits + 1;
    if (bits == 8) got_q.push_back(sh);
  end
  // the slave owns sda from the 8th falling edge to the 9th
  always @(negedge scl) begin
    s_sda = bits == 8 && !nack_mode;
    if (bits >= 9) bits = 0;
  end
  ////////////////////////////////////////////////////////////
  // foreign traffic; halves are whole ref_clk cycles so callers stay edge aligned
  task other_start;
    m_sda = 1'b1;
    #(HALF_NS) m_scl = 1'b1;
    m_sda = 1'b0;
  endtask
  task other_clocks(input int n);
    repeat (n) begin
      #(HALF_NS) m_scl = 1'b0;
      #(HALF_NS) m_scl = 1'b1;
    end
  endtask
  task other_stop;
    m_sda = 1'b1;
    #(HALF_NS) m_scl = 1'b0;
    #(HALF_NS) m_sda = 1'b0;
  endtask
endmodule

// ### bench/testbench.sv
// self-checking testbench of the serial port unit
`timescale 1ns/1ps
module testbench;
  import spe_pkg::*;
  logic ref_clk, rstn, spi_sclk, sclk_run, start_request, stop_request, start_request_flag;
  logic tx_valid, tx_ready, tx_flag_clear, transmit_interrupt_flag, bus_busy_indicator;
  logic global_irq_enable, irq_request, irq_hazard, p_scl, p_sda, scl_i, sda_i;
  logic scl_o, scl_oe, sda_o, sda_oe, spi_cs_n, spi_mosi, spi_miso, spi_tx_write;
  logic clock_phase_select, bit_order_select, spi_rx_valid;
  logic [BYTE_W-1:0] tx_data, spi_tx_data, spi_rx_data, mi, mo, d, msk;
  spe_ctrl_t ctrl;
  spe_flags_t event_flags, flag_clear, irq_enable;
  logic [7:0] exp_q[$];
  int num_errors, checks_done, seed, hazard_cnt, m;
  // open drain wires with pull-ups
  assign scl_i = !(scl_oe | p_scl);
  assign sda_i = !(sda_oe | p_sda);
  spe_serial_port i_dut (.*);
  spe_i2c_partner i_far (.scl(scl_i), .sda(sda_i), .scl_pd(p_scl), .sda_pd(p_sda));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // link clock runs only while sclk_run is set, from four cycles before a spi frame to its end
  initial begin
    spi_sclk = 1'b0;
    #7;
    forever #32 spi_sclk = sclk_run ? ~spi_sclk : 1'b0;
  end
  always @(negedge ref_clk) if (irq_hazard === 1'b1) hazard_cnt = hazard_cnt + 1;
  ////////////////////////////////////////////////////////////
  task cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      num_errors = num_errors + 1;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // valid stays up between pushes; the caller lowers it
  task push(input logic [7:0] b);
    int i;
    tx_data = b;
    tx_valid = 1'b1;
    for (i = 0; i < 50 && tx_ready !== 1'b1; i++) cyc(1);
    cyc(1);
  endtask
  task i2c_run(input int n, input bit busy);
    int i;
    flag_clear = 3'h7;
    cyc(1);
    flag_clear = 3'h0;
    i_far.got_q.delete();
    exp_q = {};
    exp_q.push_back({ctrl.slave_addr, !ctrl.transmitter_select});
    if (!busy) chk(bus_busy_indicator, 0);
    start_request = 1'b1;
    cyc(1);
    start_request = 1'b0;
    if (busy) begin
      cyc(6);
      chk(sda_oe | scl_oe, 0);
      push(8'h5A);
      tx_valid = 1'b0;
      tx_flag_clear = 1'b1;
      cyc(1);
      tx_flag_clear = 1'b0;
      i_far.other_clocks(9);
      cyc(4);
      chk(transmit_interrupt_flag, 1);
      i_far.other_stop();
      i_far.got_q.delete();
    end
    for (i = 0; i < 4000 && start_request_flag !== 1'b0; i++) cyc(1);
    chk(start_request_flag, 0);
    for (i = 0; i < n; i++) begin
      exp_q.push_back(8'($random(seed)));
      push(exp_q[i + 1]);
    end
    tx_valid = 1'b0;
    // every transfer ends in a stop, so no repeated start is ever issued
    stop_request = 1'b1;
    cyc(1);
    stop_request = 1'b0;
    for (i = 0; i < 9000 && event_flags.stop_detected !== 1'b1; i++) cyc(1);
    chk(8'(i_far.got_q.size()), 8'(exp_q.size()));
    foreach (exp_q[i]) chk(i_far.got_q[i], exp_q[i]);
  endtask
  // a bus start lands in the same cycle as the global enable rises
  task gie_race(input spe_flags_t en, input int exp_pulses);
    global_irq_enable = 1'b0;
    irq_enable = en;
    hazard_cnt = 0;
    cyc(2);
    fork
      i_far.other_start();
      begin
        cyc(2);
        global_irq_enable = 1'b1;
      end
    join
    chk(8'(hazard_cnt != 0), 8'(exp_pulses));
    chk(event_flags.not_ack, 0);
    i_far.other_clocks(9);
    i_far.other_stop();
  endtask
  task spi_xfer(input bit wr);
    int i;
    mo = 8'($random(seed));
    if (wr) begin
      spi_tx_data = d;
      spi_tx_write = 1'b1;
      cyc(1);
      spi_tx_write = 1'b0;
    end
    cyc(4);
    sclk_run = 1'b1;
    repeat (4) @(negedge spi_sclk);
    for (i = 0; i < 8; i++) begin
      mi[bit_order_select ? 7 - i : i] = spi_miso;
      spi_mosi = mo[bit_order_select ? 7 - i : i];
      spi_cs_n = 1'b0;
      @(negedge spi_sclk);
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    sclk_run = 1'b0;
    for (i = 0; i < 10 && spi_rx_valid !== 1'b1; i++) cyc(1);
    chk(spi_rx_data, mo);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    #2000000;
    num_errors = num_errors + 1;
    $display("wrong value at %0t ns: run did not finish", $time);
    complete_run();
  end
  initial begin
    seed = 95046;
    {num_errors, checks_done, hazard_cnt} = '0;
    {rstn, sclk_run, start_request, stop_request, tx_valid, tx_data, tx_flag_clear} = '0;
    {flag_clear, irq_enable, global_irq_enable, spi_mosi, spi_tx_data, spi_tx_write} = '0;
    {clock_phase_select, bit_order_select} = '0;
    spi_cs_n = 1'b1;
    ctrl = '{1'b1, 1'b1, 7'($random(seed))};
    repeat (5) @(negedge ref_clk);
    rstn = 1'b1;
    cyc(2);
    chk({start_request_flag, bus_busy_indicator, event_flags, irq_request, scl_o, sda_o}, 8'h00);
    chk(tx_ready, 1);
    $display("test reset done");
    i2c_run(3, 1'b0);
    $display("test transfer done");
    i_far.other_start();
    i2c_run(2, 1'b1);
    $display("test busy wait done");
    i_far.nack_mode = 1'b1;
    irq_enable = 3'h4;
    global_irq_enable = 1'b1;
    ctrl.transmitter_select = 1'b0;
    i2c_run(0, 1'b0);
    ctrl.transmitter_select = 1'b1;
    i_far.nack_mode = 1'b0;
    chk(event_flags.not_ack, 1);
    chk(irq_request, 1);
    gie_race(3'h4, 1);
    gie_race(3'h0, 0);
    $display("test nack and interrupt race done");
    for (m = 0; m < 4; m++) begin
      {bit_order_select, clock_phase_select} = m[1:0];
      d = 8'($random(seed));
      cyc(4);
      spi_xfer(1'b1);
      chk(mi, d);
      spi_xfer(1'b0);
      msk = clock_phase_select ? (bit_order_select ? 8'hFE : 8'h7F) : 8'hFF;
      mo = clock_phase_select ? (bit_order_select ? d << 1 : d >> 1) : d;
      chk(mi & msk, mo & msk);
      spi_xfer(1'b1);
      chk(mi, d);
    end
    $display("test spi done");
    complete_run();
  end
endmodule
